//--- src/sram_port_pkg.sv
// Shared constants and types for the burst-of-four common-I/O SRAM port.
// Imported by the port module in this folder and by the bench and monitor.
package sram_port_pkg;

    // Array organisation: 1M words of 36 bits, four 9-bit lanes
    localparam int DATA_W  = 36;                    // Word width
    localparam int LANE_W  = 9;                     // Bits per byte lane
    localparam int LANES   = 4;                     // Lanes per word
    localparam int ROW_W   = 18;                    // Upper address pins
    localparam int BURST_W = 2;                     // Burst-count address bits
    localparam int ADDR_W  = ROW_W + BURST_W;       // Full word address
    localparam int BEATS   = 4;                     // Fixed burst length
    localparam int DEPTH   = 1 << ADDR_W;           // Words in the array

    // Pipeline stages behind an accepted command
    localparam int WR_STAGES = 3;                   // Cmd, beat 1, beats 2-3
    localparam int RD_STAGES = 3;                   // Cmd, fetch, beats 1-2

    // Read/write select encoding at the command edge
    localparam logic CMD_READ = 1'b1;               // High selects a read

    // Output clocks seen high together for this many clk samples means tied high
    localparam logic [2:0] TIED_HIGH_CNT = 3'h4;
    localparam logic [2:0] TIED_CNT_RST  = 3'h0;

    // Reset values
    localparam logic BUSY_RST = 1'b0;
    localparam logic OE_N_RST = 1'b1;              // Bus released

    typedef logic [DATA_W-1:0] word_t;
    typedef logic [LANES-1:0]  lane_t;
    typedef logic [ADDR_W-1:0] addr_t;

    // Output sequencer on the output clock, Gray along idle-beat1-beat3
    typedef enum logic [1:0] {
        OUT_IDLE  = 2'b00,
        OUT_BEAT1 = 2'b01,
        OUT_BEAT3 = 2'b11
    } out_state_e;

endpackage

//--- src/sram_port.sv
// Device-side logic of a synchronous common-I/O SRAM with a fixed burst of four.
// Assumes clk is the true main input clock; its falling edge stands for the
// rising edge of the complementary main clock. out_clk/out_clk_n come from the
// far controller and may be tied high. Command, address and data pins are
// synchronous to clk; dll_off_n and the output clocks are not.
`timescale 1ns/1ps
`default_nettype none

module sram_port (
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire logic                         out_clk,
    input  wire logic                         out_clk_n,
    input  wire logic                         load_strobe_n,
    input  wire logic                         rw_sel,
    input  wire logic [sram_port_pkg::ROW_W-1:0] mem_addr,
    input  wire logic                         burst_cnt_addr_0,
    input  wire logic                         burst_cnt_addr_1,
    input  wire logic [sram_port_pkg::DATA_W-1:0] dq_in,
    input  wire logic                         lane_en_n_0,
    input  wire logic                         lane_en_n_1,
    input  wire logic                         lane_en_n_2,
    input  wire logic                         lane_en_n_3,
    input  wire logic                         dll_off_n,
    output logic [sram_port_pkg::DATA_W-1:0]  dq_out,
    output logic                              dq_oe_n,
    output logic                              echo_clk,
    output logic                              echo_clk_n,
    output logic                              dll_active
);
    import sram_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Location of beat k: row fixed, burst bits count on and wrap
    function automatic addr_t burst_loc(input addr_t base, input logic [BURST_W-1:0] k);
        burst_loc = {base[ADDR_W-1:BURST_W], base[BURST_W-1:0] + k};
    endfunction

    // Byte merge: a low enable takes the new lane, a high one keeps the old
    function automatic word_t lane_merge(input word_t old_w, input word_t new_w, input lane_t en_n);
        lane_merge = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!en_n[i]) begin
                lane_merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    word_t      mem [0:DEPTH-1];          // Storage array, no reset
    logic       busy;                     // Second cycle of an operation
    logic       cmd_take;                 // Command accepted this edge
    addr_t      cmd_addr;                 // Address presented on the pins
    lane_t      lane_en_n;                // Lane enables as a vector
    logic [WR_STAGES-1:0] wr_stage;       // Write tokens in flight
    logic [RD_STAGES-1:0] rd_stage;       // Read tokens in flight
    addr_t      wr_addr [WR_STAGES];      // Write address per stage
    addr_t      rd_addr;                  // Address of the read being fetched
    word_t      neg_dq;                   // Data caught on the falling edge
    lane_t      neg_en_n;                 // Enables caught on the falling edge
    word_t      wbuf [BEATS-1];           // Write buffer, beats one to three
    lane_t      wen_n [BEATS-1];          // Their lane enables
    word_t      commit_dq [BEATS];        // Full burst at the commit edge
    lane_t      commit_en_n [BEATS];      // Its enables
    word_t      rd_buf [BEATS];           // Fetched read burst
    logic       rd_toggle;                // Flips once per fetched burst
    word_t      kpos_dq;                  // Clk-timed beats two and four
    word_t      kneg_dq;                  // Clk-timed beats one and three
    logic       kpos_oe_n;
    logic       kneg_oe_n;
    logic       oc_s1, oc_s2;             // Output clock seen from clk
    logic       ocn_s1, ocn_s2;
    logic [2:0] tied_cnt;                 // Samples with both output clocks high
    logic       bypass;                   // Output clocks tied high
    logic       dll_s1, dll_s2;           // DLL-off pin synchroniser
    logic       crst_s1, crst;            // Reset in the output clock domain
    logic       tg_s1, tg_s2, tg_seen;    // Burst toggle synchroniser
    word_t      c_buf [BEATS];            // Burst owned by the output domain
    out_state_e out_state;                // Output sequencer
    word_t      cpos_dq;
    word_t      cneg_dq;
    logic       cpos_oe_n;
    logic       cneg_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Command capture on the clk rising edge

    // Pins gathered; the controller keeps them synchronous to clk
    assign cmd_addr  = {mem_addr, burst_cnt_addr_1, burst_cnt_addr_0};
    assign lane_en_n = {lane_en_n_3, lane_en_n_2, lane_en_n_1, lane_en_n_0};

    // A command in the cycle after another is ignored: bursts take two cycles
    assign cmd_take = !load_strobe_n && !busy;

    // Busy covers the second cycle of every accepted operation
    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= BUSY_RST;
        end else begin
            busy <= cmd_take;
        end
    end

    // Token shift registers: one bit per accepted command and stage
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_stage <= '0;
            rd_stage <= '0;
        end else begin
            wr_stage <= {wr_stage[WR_STAGES-2:0], cmd_take && (rw_sel != CMD_READ)};
            rd_stage <= {rd_stage[RD_STAGES-2:0], cmd_take && (rw_sel == CMD_READ)};
        end
    end

    // Addresses ride along with their tokens
    always_ff @(posedge clk) begin
        if (cmd_take) begin
            wr_addr[0] <= cmd_addr;
            rd_addr    <= cmd_addr;
        end
        for (int s = 1; s < WR_STAGES; s++) begin
            wr_addr[s] <= wr_addr[s-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write data path

    // Falling edge catches beats two and four; only the write stages pick them up
    always_ff @(negedge clk) begin
        neg_dq   <= dq_in;
        neg_en_n <= lane_en_n;
    end

    // Beat one a cycle after the command, beats two and three a cycle later
    always_ff @(posedge clk) begin
        if (wr_stage[0]) begin
            wbuf[0]  <= dq_in;
            wen_n[0] <= lane_en_n;
        end
        if (wr_stage[1]) begin
            wbuf[1]  <= neg_dq;
            wen_n[1] <= neg_en_n;
            wbuf[2]  <= dq_in;
            wen_n[2] <= lane_en_n;
        end
    end

    // Whole burst as it stands at the commit edge; beat four is still in the fall register
    always_comb begin
        for (int b = 0; b < BEATS - 1; b++) begin
            commit_dq[b]   = wbuf[b];
            commit_en_n[b] = wen_n[b];
        end
        commit_dq[BEATS-1]   = neg_dq;
        commit_en_n[BEATS-1] = neg_en_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array: commit and fetch

    // Commit three cycles after the write command; fetch one cycle after a read.
    // The only overlap is a read right behind a write, which is forwarded.
    always_ff @(posedge clk) begin
        if (wr_stage[2]) begin
            for (int b = 0; b < BEATS; b++) begin
                mem[burst_loc(wr_addr[2], 2'(b))] <=
                    lane_merge(mem[burst_loc(wr_addr[2], 2'(b))], commit_dq[b], commit_en_n[b]);
            end
        end
        if (rd_stage[0]) begin
            for (int b = 0; b < BEATS; b++) begin
                rd_buf[b] <= mem[burst_loc(rd_addr, 2'(b))];
                for (int j = 0; j < BEATS; j++) begin
                    if (wr_stage[2] && (burst_loc(wr_addr[2], 2'(j)) == burst_loc(rd_addr, 2'(b)))) begin
                        rd_buf[b] <= lane_merge(mem[burst_loc(rd_addr, 2'(b))],
                                                commit_dq[j], commit_en_n[j]);
                    end
                end
            end
        end
    end

    // Announces each fetched burst to the output clock domain
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_toggle <= 1'b0;
        end else if (rd_stage[0]) begin
            rd_toggle <= ~rd_toggle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clk-timed read output, used when the output clocks are tied high

    // Rising edges: beat two then beat four
    always_ff @(posedge clk) begin
        if (srst) begin
            kpos_oe_n <= OE_N_RST;
            kpos_dq   <= '0;
        end else if (rd_stage[1]) begin
            kpos_oe_n <= 1'b0;
            kpos_dq   <= rd_buf[1];
        end else if (rd_stage[2]) begin
            kpos_oe_n <= 1'b0;
            kpos_dq   <= rd_buf[3];
        end else begin
            kpos_oe_n <= 1'b1;
        end
    end

    // Falling edges: beat one 1.5 cycles after the command, then beat three
    always_ff @(negedge clk) begin
        if (srst) begin
            kneg_oe_n <= OE_N_RST;
            kneg_dq   <= '0;
        end else if (rd_stage[1]) begin
            kneg_oe_n <= 1'b0;
            kneg_dq   <= rd_buf[0];
        end else if (rd_stage[2]) begin
            kneg_oe_n <= 1'b0;
            kneg_dq   <= rd_buf[2];
        end else begin
            kneg_oe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tied-high detection and DLL control, both seen through synchronisers

    // Two flops per asynchronous pin before anything looks at them
    always_ff @(posedge clk) begin
        oc_s1  <= out_clk;
        oc_s2  <= oc_s1;
        ocn_s1 <= out_clk_n;
        ocn_s2 <= ocn_s1;
        dll_s1 <= dll_off_n;
        dll_s2 <= dll_s1;
    end

    // Running complementary clocks are never both high for long; tied ones are
    always_ff @(posedge clk) begin
        if (srst) begin
            tied_cnt <= TIED_CNT_RST;
            bypass   <= 1'b0;
        end else begin
            if (!(oc_s2 && ocn_s2)) begin
                tied_cnt <= TIED_CNT_RST;
            end else if (tied_cnt != TIED_HIGH_CNT) begin
                tied_cnt <= tied_cnt + 3'h1;
            end
            bypass <= (tied_cnt == TIED_HIGH_CNT);
        end
    end

    // Delay-locked loop runs only while the pin is high
    always_ff @(posedge clk) begin
        if (srst) begin
            dll_active <= 1'b0;
        end else begin
            dll_active <= dll_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output clock domain

    // Reset carried over as a level
    always_ff @(posedge out_clk) begin
        crst_s1 <= srst;
        crst    <= crst_s1;
    end

    // Toggle crossing; the burst words are read only after the toggle settled.
    // Limitation: the read buffer must hold until then, so reads in this mode
    // need spacing of at least three output clock periods.
    always_ff @(posedge out_clk) begin
        if (crst) begin
            tg_s1   <= 1'b0;
            tg_s2   <= 1'b0;
            tg_seen <= 1'b0;
        end else begin
            tg_s1   <= rd_toggle;
            tg_s2   <= tg_s1;
            tg_seen <= tg_s2;
        end
    end

    // Take over the burst when a new one is announced
    always_ff @(posedge out_clk) begin
        if (tg_s2 != tg_seen) begin
            for (int b = 0; b < BEATS; b++) begin
                c_buf[b] <= rd_buf[b];
            end
        end
    end

    // Sequencer: beat one waits for the next complementary rise
    always_ff @(posedge out_clk) begin
        if (crst) begin
            out_state <= OUT_IDLE;
        end else begin
            case (out_state)
                OUT_IDLE: begin
                    out_state <= (tg_s2 != tg_seen) ? OUT_BEAT1 : OUT_IDLE;
                end
                OUT_BEAT1: begin
                    out_state <= OUT_BEAT3;
                end
                OUT_BEAT3: begin
                    out_state <= (tg_s2 != tg_seen) ? OUT_BEAT1 : OUT_IDLE;
                end
                default: begin
                    out_state <= OUT_IDLE;
                end
            endcase
        end
    end

    // True output clock rises carry beats two and four
    always_ff @(posedge out_clk) begin
        if (crst) begin
            cpos_oe_n <= OE_N_RST;
            cpos_dq   <= '0;
        end else if (out_state == OUT_BEAT1) begin
            cpos_oe_n <= 1'b0;
            cpos_dq   <= c_buf[1];
        end else if (out_state == OUT_BEAT3) begin
            cpos_oe_n <= 1'b0;
            cpos_dq   <= c_buf[3];
        end else begin
            cpos_oe_n <= 1'b1;
        end
    end

    // Complementary rises (true clock falls) carry beats one and three
    always_ff @(negedge out_clk) begin
        if (crst) begin
            cneg_oe_n <= OE_N_RST;
            cneg_dq   <= '0;
        end else if (out_state == OUT_BEAT1) begin
            cneg_oe_n <= 1'b0;
            cneg_dq   <= c_buf[0];
        end else if (out_state == OUT_BEAT3) begin
            cneg_oe_n <= 1'b0;
            cneg_dq   <= c_buf[2];
        end else begin
            cneg_oe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    // Double-rate output: the timing clock level picks the edge register.
    // Echo clocks are that same clock, so their edges sit on the data edges.
    assign dq_out     = bypass ? (clk ? kpos_dq : kneg_dq) : (out_clk ? cpos_dq : cneg_dq);
    assign dq_oe_n    = bypass ? (clk ? kpos_oe_n : kneg_oe_n) : (out_clk ? cpos_oe_n : cneg_oe_n);
    assign echo_clk   = bypass ? clk : out_clk;
    assign echo_clk_n = ~echo_clk;

endmodule

`default_nettype wire

//--- tb/sram_port_monitor.sv
// Checker for the SRAM port: output enable timing, echo clocks, DLL status.
// Assumes it is bound to sram_port and no command comes before reset ends.
`timescale 1ns/1ps
`default_nettype none
module sram_port_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic out_clk,
    input wire logic out_clk_n,
    input wire logic load_strobe_n,
    input wire logic rw_sel,
    input wire logic dll_off_n,
    input wire logic dq_oe_n,
    input wire logic echo_clk,
    input wire logic echo_clk_n,
    input wire logic dll_active
);
    import sram_port_pkg::*;
    logic       take;     // Command accepted at this rise
    logic       took;     // Command accepted at the last rise
    logic       tied;     // Output clocks parked high long enough
    logic [3:0] tied_cnt; // Rises with both output clocks high
    logic [3:0] run_cnt;  // Rises since both were last high
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    assign take = !load_strobe_n && !took;
    assign tied = tied_cnt >= 4'hA;
    // A strobe on the rise after a command is dropped, so track acceptance
    always_ff @(posedge clk) begin
        took <= srst ? 1'b0 : take;
    end
    // Saturating counters; margin covers the synchroniser in the detector
    always_ff @(posedge clk) begin
        if (srst || !(out_clk && out_clk_n)) begin
            tied_cnt <= 4'h0;
        end else if (tied_cnt != 4'hF) begin
            tied_cnt <= tied_cnt + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || (out_clk && out_clk_n)) begin
            run_cnt <= 4'h0;
        end else if (run_cnt != 4'hF) begin
            run_cnt <= run_cnt + 4'h1;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    property p_dll_off; !dll_off_n [*4] |-> !dll_active; endproperty
    a_dll_off: assert property (p_dll_off) else $error("dll active while disabled");
    property p_dll_on; (dll_off_n && !srst) [*6] |-> dll_active; endproperty
    a_dll_on: assert property (p_dll_on) else $error("dll not active");
    property p_dll_rst; disable iff (1'b0) srst |=> !dll_active; endproperty
    a_dll_rst: assert property (p_dll_rst) else $error("dll active in reset");
    property p_echo_n; echo_clk_n == !echo_clk; endproperty
    a_echo_n: assert property (p_echo_n) else $error("echo pair not complementary");
    property p_echo_tied; tied |-> echo_clk == clk; endproperty
    a_echo_tied: assert property (p_echo_tied) else $error("echo not from clk");
    property p_echo_run; run_cnt >= 4'h8 |-> echo_clk == out_clk; endproperty
    a_echo_run: assert property (p_echo_run) else $error("echo not from out_clk");
    property p_oe_rd;
        tied && take && rw_sel == CMD_READ && !$past(take && rw_sel, 2) |=> dq_oe_n ##1 !dq_oe_n [*2];
    endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("read drive window wrong");
    property p_oe_idle; (tied && !take) [*4] |-> dq_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("bus driven while idle");
    property p_oe_wr;
        tied && take && rw_sel != CMD_READ && !$past(take && rw_sel, 2) |=> dq_oe_n [*2];
    endproperty
    a_oe_wr: assert property (p_oe_wr) else $error("bus driven on write");
endmodule
bind sram_port sram_port_monitor i_sram_port_monitor (.clk(clk), .srst(srst), .out_clk(out_clk),
    .out_clk_n(out_clk_n), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel), .dll_off_n(dll_off_n),
    .dq_oe_n(dq_oe_n), .echo_clk(echo_clk), .echo_clk_n(echo_clk_n), .dll_active(dll_active));
`default_nettype wire

//--- tb/sram_ctrl_clk_model.sv
// Far side: the controller's output timing clock pair.
// Assumes the bench parks it high only between read bursts.
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_clk_model (
    input  wire logic tied,      // Park both clocks high
    output logic      out_clk,   // True output clock
    output logic      out_clk_n  // Complementary output clock
);
    logic phase; // 80 ns period, offset so no edge meets a clk edge
    initial begin
        phase = 1'b0;
        #3;
        forever #40 phase = ~phase;
    end
    // Parked high, the device must time reads from clk instead
    assign out_clk   = tied ? 1'b1 : phase;
    assign out_clk_n = tied ? 1'b1 : ~phase;
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for sram_port: bursts, lane masks, refusal, coherency.
// Assumes the clock-pair model beside it; the bench plays the controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sram_port_pkg::*;
    logic             clk, srst, tied, load_strobe_n, rw_sel, dll_off_n;
    logic             out_clk, out_clk_n, burst_cnt_addr_0, burst_cnt_addr_1;
    logic [ROW_W-1:0] mem_addr;
    word_t            dq_in, dq_out;
    lane_t            lane_n;    // Lane enables, active low
    logic             dq_oe_n, echo_clk, echo_clk_n, dll_active;
    int               bad_count, total_checks, cycles;
    word_t            exp_mem [addr_t]; // Expected array contents
    sram_port i_sram_port (.clk(clk), .srst(srst), .out_clk(out_clk), .out_clk_n(out_clk_n),
        .load_strobe_n(load_strobe_n), .rw_sel(rw_sel), .mem_addr(mem_addr),
        .burst_cnt_addr_0(burst_cnt_addr_0), .burst_cnt_addr_1(burst_cnt_addr_1), .dq_in(dq_in),
        .lane_en_n_0(lane_n[0]), .lane_en_n_1(lane_n[1]), .lane_en_n_2(lane_n[2]),
        .lane_en_n_3(lane_n[3]), .dll_off_n(dll_off_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .echo_clk(echo_clk), .echo_clk_n(echo_clk_n), .dll_active(dll_active));
    sram_ctrl_clk_model i_sram_ctrl_clk_model (.tied(tied), .out_clk(out_clk), .out_clk_n(out_clk_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard: the run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input word_t got, input word_t exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Command at the falling edge, taken at the next rise
    task automatic issue(input logic rd, input logic [ROW_W-1:0] row, input logic [1:0] st);
        @(negedge clk);
        load_strobe_n = 1'b0;
        rw_sel = rd;
        mem_addr = row;
        {burst_cnt_addr_1, burst_cnt_addr_0} = st;
        @(posedge clk);
    endtask
    // Mode 1 holds the strobe into the busy rise; mode 2 chains a read at E2
    task automatic wr_burst(input logic [ROW_W-1:0] row, input logic [1:0] st, input word_t d[4],
                            input lane_t m[4], input int mode);
        addr_t a;
        issue(1'b0, row, st);
        @(negedge clk);
        load_strobe_n = (mode != 1);
        rw_sel = 1'b1;
        dq_in <= d[0];
        lane_n <= m[0];
        @(posedge clk);
        #2 dq_in = d[1];
        lane_n = m[1];
        @(negedge clk);
        load_strobe_n = (mode != 2);
        // Nonblocking: the fall register still has to take beat two here
        dq_in <= d[2];
        lane_n <= m[2];
        @(posedge clk);
        #2 dq_in = d[3];
        lane_n = m[3];
        for (int b = 0; b < BEATS; b++) begin
            a = {row, st + 2'(b)};
            for (int l = 0; l < LANES; l++) begin
                if (!m[b][l]) exp_mem[a][l*LANE_W +: LANE_W] = d[b][l*LANE_W +: LANE_W];
            end
        end
    endtask
    // Read timed from clk; command edge E0 has just passed
    task automatic rd_tied(input logic [ROW_W-1:0] row, input logic [1:0] st);
        @(negedge clk);
        load_strobe_n = 1'b1;
        @(posedge clk);
        for (int b = 0; b < BEATS; b++) begin
            if (b % 2 == 0) @(negedge clk);
            else @(posedge clk);
            #2;
            chk(dq_out, exp_mem[{row, st + 2'(b)}], "tied beat");
            chk({35'h0, dq_oe_n}, 36'h0, "tied oe");
            chk({35'h0, echo_clk}, {35'h0, clk}, "tied echo");
        end
        @(negedge clk);
        #2 chk({35'h0, dq_oe_n}, 36'h1, "oe after burst");
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic t_dll();
        chk({35'h0, dll_active}, 36'h0, "dll off");
        @(negedge clk) dll_off_n = 1'b1;
        repeat (5) @(negedge clk);
        chk({35'h0, dll_active}, 36'h1, "dll on");
        dll_off_n = 1'b0;
        repeat (5) @(negedge clk);
        chk({35'h0, dll_active}, 36'h0, "dll off again");
        dll_off_n = 1'b1;
        $display("t_dll done");
    endtask
    task automatic t_run_read();
        int w;
        wr_burst(18'h00ABC, 2'h1, '{36'h1_2345_6789, 36'hF_EDCB_A987, 36'h5_A5A5_A5A5, 36'hA_5A5A_5A5A},
                 '{4'h0, 4'h0, 4'h0, 4'h0}, 0);
        issue(1'b1, 18'h00ABC, 2'h1);
        @(negedge clk) load_strobe_n = 1'b1;
        for (w = 0; w < 2000 && dq_oe_n !== 1'b0; w++) #1;
        #2;
        for (int b = 0; b < BEATS; b++) begin
            if (b == 1 || b == 3) @(posedge out_clk) #20;
            else if (b == 2) @(negedge out_clk) #20;
            chk(dq_out, exp_mem[{18'h00ABC, 2'h1 + 2'(b)}], "clocked beat");
            chk({34'h0, echo_clk, echo_clk_n}, {34'h0, out_clk, ~out_clk}, "echo");
        end
        @(negedge out_clk) #20 chk({35'h0, dq_oe_n}, 36'h1, "oe released");
        $display("t_run_read done");
    endtask
    task automatic t_tied_read();
        tied = 1'b1;
        repeat (20) @(posedge clk);
        issue(1'b1, 18'h00ABC, 2'h3);
        rd_tied(18'h00ABC, 2'h3);
        $display("t_tied_read done");
    endtask
    task automatic t_masked_refused();
        wr_burst(18'h00ABC, 2'h2, '{36'h0_1111_1111, 36'h2_2222_2222, 36'h3_3333_3333, 36'h4_4444_4444},
                 '{4'hE, 4'h5, 4'hF, 4'h0}, 1);
        repeat (4) @(negedge clk) #2 chk({35'h0, dq_oe_n}, 36'h1, "refused read");
        issue(1'b1, 18'h00ABC, 2'h0);
        rd_tied(18'h00ABC, 2'h0);
        $display("t_masked_refused done");
    endtask
    task automatic t_coherent();
        wr_burst(18'h3FFFF, 2'h0, '{36'hC_0DE0_0001, 36'hC_0DE0_0002, 36'hC_0DE0_0003, 36'hC_0DE0_0004},
                 '{4'h0, 4'h0, 4'h0, 4'h0}, 2);
        rd_tied(18'h3FFFF, 2'h0);
        $display("t_coherent done");
    endtask
    initial begin
        {srst, tied, load_strobe_n, rw_sel, dll_off_n} = 5'b10100;
        {burst_cnt_addr_1, burst_cnt_addr_0, mem_addr, dq_in, lane_n} = {2'h0, 18'h0, 36'h0, 4'hF};
        // Long enough for three output clock rises, which the link side needs
        repeat (32) @(posedge clk);
        @(negedge clk) srst <= 1'b0;
        t_dll();
        t_run_read();
        t_tied_read();
        t_masked_refused();
        t_coherent();
        final_report();
    end
endmodule
`default_nettype wire
